// >>> rtl/dfd_dev_end.sv
// Display side DMA logic: paces host word transfers into and out of the FIFOs.
// Assumes the host drives the link on i_ref_clk and holds write data for the
// whole acknowledge low time; FIFO loads come from logic on the same clock.
//
// How it works
// - Request is signalled by driving it high.
// - Host acknowledges by pulling acknowledge low.
// - Acknowledge counts only with our chip select.
// - Stop output halts the host DMA controller.
// - Host should disable its channel before ours.
// - Demand level mode and edge mode both supported.
// - Demand length equals free or stored words.
// - Load counter, request until zero, then repeat.
// - Start when limit meets the FIFO load.
// - Request falls at zero count, edge acknowledge, full buffer or disable.
// - Full demand fill covers sixty four words.
// - Host starts edge transfers on rising request.
// - Edge request drops on first qualified acknowledge.
// - Toggle after each acknowledge, blind to host mode.
// - Software limits keep host blocks within FIFOs.
// - Data words travel the ordinary bus path.
// - Enable falling during transfer fires the stop.
// - Stop pulse length field, resets to seven.
// - Mode bit set selects demand, resets clear.
// - Direction set selects input FIFO, resets set.
`timescale 1ns/1ns
module dfd_dev_end (
   input  wire logic        i_ref_clk,               // Host bus clock.
   input  wire logic        i_srst,                  // Synchronous reset, high.
   dfd_link_if.device       link,                    // Link to the host.
   input  wire logic        i_cfg_wr,                // Loads all settings below.
   input  wire logic        i_dma_global_enable,     // DMA enable.
   input  wire logic        i_dma_mode_select,       // 1 demand, 0 edge mode.
   input  wire logic        i_dma_direction_select,  // 1 input FIFO, 0 output.
   input  wire logic [4:0]  i_stop_len,              // Stop pulse length.
   input  wire logic [6:0]  i_input_fifo_lower_limit,
   input  wire logic [6:0]  i_output_fifo_upper_limit,
   input  wire logic [6:0]  i_in_fifo_load,          // Words in input FIFO.
   input  wire logic [6:0]  i_out_fifo_load,         // Words in output FIFO.
   output logic             o_wr_valid,              // Buffered host word ready.
   output logic [31:0]      o_wr_data,               // Buffered host word.
   input  wire logic        i_wr_ready,              // Input FIFO takes word.
   input  wire logic [31:0] i_rd_data,               // Head of output FIFO.
   output logic             o_rd_pop,                // Output FIFO advance.
   output logic             o_busy                   // Request machine active.
);

   // All state of this end lives in one packed record.
   typedef struct packed {
      dfd_pkg::dfd_dev_st_t st;        // Request machine state.
      logic                 en;        // Global enable setting.
      logic                 demand;    // Mode setting.
      logic                 dir_in;    // Direction setting.
      logic [4:0]           stop_len;  // Stop pulse length setting.
      logic [6:0]           in_ll;     // Input FIFO lower limit.
      logic [6:0]           out_ul;    // Output FIFO upper limit.
      logic                 en_d;      // Enable one cycle ago.
      logic                 ack_s1;    // Acknowledge, first sync stage.
      logic                 ack_s2;    // Acknowledge, second sync stage.
      logic                 cs_s1;     // Chip select, first sync stage.
      logic                 cs_s2;     // Chip select, second sync stage.
      logic                 qual_d;    // Qualified acknowledge one cycle ago.
      logic [31:0]          wd_s1;     // Write data, first sync stage.
      logic [31:0]          wd_s2;     // Write data, second sync stage.
      logic [6:0]           cnt;       // Demand words still to request.
      logic [4:0]           stop_cnt;  // Stop pulse cycles left.
      logic                 req;       // Request pin.
      logic                 stop;      // Stop pin.
      logic [31:0]          rdata;     // Read data pin.
      logic                 rd_pop;    // Output FIFO advance pulse.
      logic                 busy;      // Machine not idle.
      logic [1:0]           vld;       // Buffer entry valid bits.
      logic [31:0]          buf0;      // Buffer head entry.
      logic [31:0]          buf1;      // Buffer second entry.
   } dfd_dev_rec_t;

   dfd_dev_rec_t r_r;                  // Registered state.
   dfd_dev_rec_t r_nxt;                // Next state.

   // Outputs come straight from the record's flip-flops.
   assign link.dma_request_out   = r_r.req;
   assign link.host_dma_stop_out = r_r.stop;
   assign link.host_rd_data      = r_r.rdata;
   assign o_wr_valid             = r_r.vld[0];
   assign o_wr_data              = r_r.buf0;
   assign o_rd_pop               = r_r.rd_pop;
   assign o_busy                 = r_r.busy;

   // Next state of the whole end.
   always_comb begin
      logic       qual;
      logic       take;
      logic       start;
      logic       room;
      logic       fall;
      logic [6:0] words;
      logic [1:0] v;
      logic [31:0] b0;
      logic [31:0] b1;
      qual  = 1'b0;
      take  = 1'b0;
      start = 1'b0;
      room  = 1'b0;
      fall  = 1'b0;
      words = 7'h00;
      v     = r_r.vld;
      b0    = r_r.buf0;
      b1    = r_r.buf1;
      r_nxt = r_r;

      // Link pins pass two flip-flops before anything looks at them.
      r_nxt.ack_s1 = link.dma_acknowledge_in_n;
      r_nxt.ack_s2 = r_r.ack_s1;
      r_nxt.cs_s1  = link.host_chip_select_n;
      r_nxt.cs_s2  = r_r.cs_s1;
      r_nxt.wd_s1  = link.host_wr_data;
      r_nxt.wd_s2  = r_r.wd_s1;

      // An acknowledge low without our select belongs to another device.
      qual         = ~r_r.ack_s2 & ~r_r.cs_s2;
      take         = qual & ~r_r.qual_d & r_r.en;
      r_nxt.qual_d = qual;

      // Settings load as one group so mode and direction never mix.
      if (i_cfg_wr) begin
         r_nxt.en       = i_dma_global_enable;
         r_nxt.demand   = i_dma_mode_select;
         r_nxt.dir_in   = i_dma_direction_select;
         r_nxt.stop_len = i_stop_len;
         r_nxt.in_ll    = i_input_fifo_lower_limit;
         r_nxt.out_ul   = i_output_fifo_upper_limit;
      end
      r_nxt.en_d = r_r.en;
      fall       = r_r.en_d & ~r_r.en;

      // Start test compares the programmed limit with the live load.
      if (r_r.dir_in) begin
         start = (r_r.in_ll >= i_in_fifo_load);
         words = dfd_pkg::FIFO_SIZE - i_in_fifo_load;
      end else begin
         start = (r_r.out_ul <= i_out_fifo_load);
         words = i_out_fifo_load;
      end

      // Each accepted word rides the ordinary data path, whatever the state,
      // because a host block may run on after our request has dropped.
      if (v[0] && i_wr_ready) begin
         b0 = b1;
         v  = {1'b0, v[1]};
      end
      if (take && r_r.dir_in && !v[1]) begin
         if (!v[0]) begin
            b0 = r_r.wd_s2;
         end else begin
            b1 = r_r.wd_s2;
         end
         v = {v[0], 1'b1};
      end
      r_nxt.vld  = v;
      r_nxt.buf0 = b0;
      r_nxt.buf1 = b1;

      // Read data follows the output FIFO head; each word read advances it.
      r_nxt.rdata  = i_rd_data;
      r_nxt.rd_pop = take & ~r_r.dir_in;

      // Request machine.
      case (r_r.st)
         dfd_pkg::DFD_S_IDLE: begin
            if (r_r.en && start) begin
               if (r_r.demand) begin
                  if (words != 7'h00) begin
                     r_nxt.cnt = words;
                     r_nxt.st  = dfd_pkg::DFD_S_DEMAND;
                  end
               end else begin
                  r_nxt.st = dfd_pkg::DFD_S_EDGE;
               end
            end
         end
         dfd_pkg::DFD_S_DEMAND: begin
            // Count words down; at zero fall back and test again.
            if (take) begin
               r_nxt.cnt = r_r.cnt - 7'h01;
               if (r_r.cnt == 7'h01) begin
                  r_nxt.st = dfd_pkg::DFD_S_IDLE;
               end
            end
         end
         dfd_pkg::DFD_S_EDGE: begin
            // Block, step and burst look alike here: one acknowledge ends it.
            if (take) begin
               r_nxt.st = dfd_pkg::DFD_S_IDLE;
            end
         end
         dfd_pkg::DFD_S_STOP: begin
            r_nxt.stop_cnt = r_r.stop_cnt - 5'h01;
            if (r_r.stop_cnt == 5'h01) begin
               r_nxt.st = dfd_pkg::DFD_S_IDLE;
            end
         end
         default: begin
            r_nxt.st = dfd_pkg::DFD_S_IDLE;
         end
      endcase

      // Disabling mid transfer aborts both controllers via the stop pin.
      if (fall && (r_r.st == dfd_pkg::DFD_S_DEMAND || r_r.st == dfd_pkg::DFD_S_EDGE)) begin
         r_nxt.st       = dfd_pkg::DFD_S_STOP;
         r_nxt.stop_cnt = (r_r.stop_len == 5'h00) ? 5'h01 : r_r.stop_len;
      end else if (!r_r.en && r_r.st != dfd_pkg::DFD_S_STOP) begin
         r_nxt.st = dfd_pkg::DFD_S_IDLE;
      end

      // A full buffer holds the demand request back so no written word is lost.
      room      = ~r_nxt.vld[1] | ~r_nxt.dir_in;
      r_nxt.req = ((r_nxt.st == dfd_pkg::DFD_S_DEMAND) && room)
                  || (r_nxt.st == dfd_pkg::DFD_S_EDGE);
      r_nxt.stop = (r_nxt.st == dfd_pkg::DFD_S_STOP);
      r_nxt.busy = (r_nxt.st != dfd_pkg::DFD_S_IDLE);
   end

   // Register the record; reset loads constants only.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         r_r          <= '0;
         r_r.st       <= dfd_pkg::DFD_S_IDLE;
         r_r.en       <= dfd_pkg::RST_ENABLE;
         r_r.demand   <= dfd_pkg::RST_MODE_DMD;
         r_r.dir_in   <= dfd_pkg::RST_DIR_IN;
         r_r.stop_len <= dfd_pkg::RST_STOP_LEN;
         r_r.in_ll    <= dfd_pkg::RST_IN_LL;
         r_r.out_ul   <= dfd_pkg::RST_OUT_UL;
         r_r.ack_s1   <= 1'b1;
         r_r.ack_s2   <= 1'b1;
         r_r.cs_s1    <= 1'b1;
         r_r.cs_s2    <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

endmodule

// >>> rtl/dfd_host_end.sv
// Host DMA channel end: answers requests with acknowledged bus cycles.
// Assumes the device end shares i_ref_clk; request and stop are synchronised.
`timescale 1ns/1ns
module dfd_host_end (
   input  wire logic        i_ref_clk,            // Host bus clock.
   input  wire logic        i_srst,               // Synchronous reset, high.
   dfd_link_if.host         link,                 // Link to the device.
   input  wire logic        i_host_channel_enable, // Channel enable.
   input  wire logic        i_host_channel_pause,  // Channel pause.
   input  wire logic        i_demand,             // 1 demand, 0 edge mode.
   input  wire logic        i_write_dir,          // 1 write to device.
   input  wire logic [7:0]  i_block_len,          // Words per rising request.
   input  wire logic [31:0] i_tx_data,            // Word to write.
   input  wire logic        i_tx_valid,           // Word to write present.
   output logic             o_tx_ready,           // Word taken, pulse.
   output logic [31:0]      o_rx_data,            // Word read.
   output logic             o_rx_valid,           // Word read, pulse.
   output logic             o_stop_err            // Stop seen, sticky.
);

   // All state of this end lives in one packed record.
   typedef struct packed {
      dfd_pkg::dfd_host_st_t st;       // Channel state.
      logic                  req_s1;   // Request, first sync stage.
      logic                  req_s2;   // Request, second sync stage.
      logic                  req_d;    // Request one cycle later.
      logic                  stp_s1;   // Stop, first sync stage.
      logic                  stp_s2;   // Stop, second sync stage.
      logic                  pend;     // Rising request not yet served.
      logic [7:0]            left;     // Edge mode words still to move.
      logic [2:0]            ph;       // Cycle within the bus phase.
      logic                  ack_n;    // Acknowledge pin.
      logic                  cs_n;     // Chip select pin.
      logic [31:0]           wdata;    // Write data pin.
      logic                  tx_rdy;   // Source pop pulse.
      logic [31:0]           rx_data;  // Read word.
      logic                  rx_vld;   // Read word pulse.
      logic                  err;      // Stop error flag.
   } dfd_host_rec_t;

   dfd_host_rec_t h_r;                 // Registered state.
   dfd_host_rec_t h_nxt;               // Next state.

   assign link.dma_acknowledge_in_n = h_r.ack_n;
   assign link.host_chip_select_n   = h_r.cs_n;
   assign link.host_wr_data         = h_r.wdata;
   assign o_tx_ready                = h_r.tx_rdy;
   assign o_rx_data                 = h_r.rx_data;
   assign o_rx_valid                = h_r.rx_vld;
   assign o_stop_err                = h_r.err;

   // Next state of the channel.
   always_comb begin
      logic go;
      logic have;
      go     = 1'b0;
      have   = 1'b0;
      h_nxt  = h_r;
      h_nxt.req_s1 = link.dma_request_out;
      h_nxt.req_s2 = h_r.req_s1;
      h_nxt.req_d  = h_r.req_s2;
      h_nxt.stp_s1 = link.host_dma_stop_out;
      h_nxt.stp_s2 = h_r.stp_s1;
      h_nxt.tx_rdy = 1'b0;
      h_nxt.rx_vld = 1'b0;
      // Edge mode reacts to the rising request only.
      if (h_r.req_s2 && !h_r.req_d && !i_demand) begin
         h_nxt.pend = 1'b1;
      end
      have = ~i_write_dir | i_tx_valid;
      case (h_r.st)
         dfd_pkg::DFD_H_IDLE: begin
            if (h_r.err) begin
               // The error stays until software turns the channel off.
               if (!i_host_channel_enable) begin
                  h_nxt.err = 1'b0;
               end
            end else if (i_host_channel_enable && !i_host_channel_pause && have) begin
               if (i_demand) begin
                  go = h_r.req_s2;
               end else if (h_r.left != 8'h00) begin
                  go         = 1'b1;
                  h_nxt.left = h_r.left - 8'h01;
               end else if (h_r.pend) begin
                  go         = 1'b1;
                  h_nxt.pend = 1'b0;
                  h_nxt.left = (i_block_len == 8'h00) ? 8'h00 : i_block_len - 8'h01;
               end
            end
            if (go) begin
               h_nxt.ack_n  = 1'b0;
               h_nxt.cs_n   = 1'b0;
               h_nxt.wdata  = i_tx_data;
               h_nxt.tx_rdy = i_write_dir;
               h_nxt.ph     = 3'h0;
               h_nxt.st     = dfd_pkg::DFD_H_LOW;
            end
         end
         dfd_pkg::DFD_H_LOW: begin
            h_nxt.ph = h_r.ph + 3'h1;
            if (h_r.ph == dfd_pkg::RD_SAMPLE_CYC && !i_write_dir) begin
               h_nxt.rx_data = link.host_rd_data;
               h_nxt.rx_vld  = 1'b1;
            end
            if (h_r.ph == dfd_pkg::ACK_LOW_CYC - 3'h1) begin
               h_nxt.ack_n = 1'b1;
               h_nxt.cs_n  = 1'b1;
               h_nxt.ph    = 3'h0;
               h_nxt.st    = dfd_pkg::DFD_H_HIGH;
            end
         end
         dfd_pkg::DFD_H_HIGH: begin
            h_nxt.ph = h_r.ph + 3'h1;
            if (h_r.ph == dfd_pkg::ACK_GAP_CYC - 3'h1) begin
               h_nxt.st = dfd_pkg::DFD_H_IDLE;
            end
         end
         default: begin
            h_nxt.st = dfd_pkg::DFD_H_IDLE;
         end
      endcase
      // Stop from the device is an error: abandon the transfer at once.
      if (h_r.stp_s2) begin
         h_nxt.err   = 1'b1;
         h_nxt.ack_n = 1'b1;
         h_nxt.cs_n  = 1'b1;
         h_nxt.left  = 8'h00;
         h_nxt.pend  = 1'b0;
         h_nxt.st    = dfd_pkg::DFD_H_IDLE;
      end
   end

   // Register the record.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         h_r       <= '0;
         h_r.st    <= dfd_pkg::DFD_H_IDLE;
         h_r.ack_n <= 1'b1;
         h_r.cs_n  <= 1'b1;
      end else begin
         h_r <= h_nxt;
      end
   end

endmodule

// >>> rtl/dfd_link_if.sv
// Link between the display side DMA logic and the host DMA controller.
// Assumes both ends share one clock; the bench joins the two modports.
`timescale 1ns/1ns
interface dfd_link_if;
   logic        dma_request_out;       // Request, active high.
   logic        host_dma_stop_out;     // Stop pulse to the host, active high.
   logic        dma_acknowledge_in_n;  // Acknowledge, active low.
   logic        host_chip_select_n;    // Chip select of this device, active low.
   logic [31:0] host_wr_data;          // Word written by the host.
   logic [31:0] host_rd_data;          // Word read by the host.

   // The documented device end.
   modport device (
      output dma_request_out,
      output host_dma_stop_out,
      output host_rd_data,
      input  dma_acknowledge_in_n,
      input  host_chip_select_n,
      input  host_wr_data
   );

   // The host DMA controller end.
   modport host (
      input  dma_request_out,
      input  host_dma_stop_out,
      input  host_rd_data,
      output dma_acknowledge_in_n,
      output host_chip_select_n,
      output host_wr_data
   );
endinterface

// >>> rtl/dfd_pkg.sv
// Shared constants and types for the display FIFO DMA request handshake.
// Assumes both ends run on the one host bus clock and include nothing else.
package dfd_pkg;

   // Width of one data word on the host bus.
   localparam int unsigned WORD_W = 32;
   // Width of a FIFO load, a limit or a demand count.
   localparam int unsigned LOAD_W = 7;
   // Width of the stop pulse length field.
   localparam int unsigned STOP_W = 5;
   // Input FIFO depth; one whole demand fill cycle is this many words.
   localparam logic [6:0] FIFO_SIZE = 7'h40;

   // Reset values of the device configuration.
   localparam logic       RST_ENABLE    = 1'b0;
   localparam logic       RST_MODE_DMD  = 1'b0;
   localparam logic       RST_DIR_IN    = 1'b1;
   localparam logic [4:0] RST_STOP_LEN  = 5'h07;
   localparam logic [6:0] RST_IN_LL     = 7'h3F;
   localparam logic [6:0] RST_OUT_UL    = 7'h01;

   // Host bus cycle timing: acknowledge low time and gap, in bus clocks.
   localparam logic [2:0] ACK_LOW_CYC  = 3'h4;
   localparam logic [2:0] ACK_GAP_CYC  = 3'h4;
   // Host cycle in the low phase at which read data is sampled.
   localparam logic [2:0] RD_SAMPLE_CYC = 3'h1;

   // Device request machine states.
   typedef enum logic [1:0] {
      DFD_S_IDLE   = 2'h0,
      DFD_S_DEMAND = 2'h1,
      DFD_S_EDGE   = 2'h2,
      DFD_S_STOP   = 2'h3
   } dfd_dev_st_t;

   // Host DMA channel states.
   typedef enum logic [1:0] {
      DFD_H_IDLE = 2'h0,
      DFD_H_LOW  = 2'h1,
      DFD_H_HIGH = 2'h2
   } dfd_host_st_t;

endpackage

// >>> sim/dfd_link_sva.sv
// Checker for the link between the display side DMA logic and the host end.
// Assumes the bench feeds it the link signals and the shared clock and reset.
`timescale 1ns/1ns
module dfd_link_sva (
   input wire logic        i_ref_clk,
   input wire logic        i_srst,
   input wire logic        dma_request_out,
   input wire logic        host_dma_stop_out,
   input wire logic        dma_acknowledge_in_n,
   input wire logic        host_chip_select_n,
   input wire logic [31:0] host_wr_data
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);

   logic [5:0] stop_cnt_r; // Cycles the current stop pulse has stood.

   // Counts stop cycles; a length field that wraps would show as a long pulse.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !host_dma_stop_out) begin
         stop_cnt_r <= 6'h00;
      end else begin
         stop_cnt_r <= stop_cnt_r + 6'h01;
      end
   end

   a_reset_quiet_link: assert property ($fell(i_srst) |->
      !dma_request_out && !host_dma_stop_out && dma_acknowledge_in_n && host_chip_select_n)
      else $error("link not quiet after reset");
   a_stop_blocks_req: assert property (host_dma_stop_out |-> !dma_request_out)
      else $error("request high during stop");
   a_stop_len_max: assert property (stop_cnt_r <= 6'h1F)
      else $error("stop pulse longer than the field allows");
   a_ack_with_select: assert property (!dma_acknowledge_in_n |-> !host_chip_select_n)
      else $error("acknowledge without chip select");
   a_ack_low_time: assert property ($fell(dma_acknowledge_in_n) |->
      !dma_acknowledge_in_n [*4] ##1 dma_acknowledge_in_n)
      else $error("acknowledge low time wrong");
   a_ack_gap_time: assert property ($rose(dma_acknowledge_in_n) |->
      dma_acknowledge_in_n [*3])
      else $error("acknowledge gap too short");
   a_wdata_held: assert property (!dma_acknowledge_in_n && $past(!dma_acknowledge_in_n)
      |-> $stable(host_wr_data))
      else $error("write word moved during acknowledge");
   a_stop_halts_host: assert property ($rose(host_dma_stop_out) |->
      ##4 dma_acknowledge_in_n [*4])
      else $error("host kept acknowledging after stop");
endmodule

// >>> sim/tb_top.sv
// Bench joining both ends, plus a second device end driven by hand.
// Assumes a 50 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
module tb_top;
   logic        i_ref_clk = 1'h0;   // Host bus clock.
   logic        i_srst    = 1'h1;   // Synchronous reset.
   logic        cfg_wr = 1'h0, en = 1'h0, mode = 1'h0, dir = 1'h1;
   logic        wr_ready = 1'h1, h_en = 1'h0, h_dmd = 1'h0, h_wr = 1'h1;
   logic [4:0]  stop_len = 5'h07;
   logic [6:0]  ll = 7'h3F, ul = 7'h01, in_load = 7'h00, out_load = 7'h00;
   logic [31:0] tx_word = 32'h5A000000, rd_head = 32'hC3000000;
   logic [31:0] exp_w = 32'h5A000000, exp_r = 32'hC3000000, wr_data, rx_data;
   logic        wr_valid, rd_pop, tx_ready, rx_valid, ack_q, req_q, busy, stop_err;
   int          mismatches = 0, n_compared = 0, ack_falls, req_falls, wcount, rcount;
   dfd_link_if  link_a ();             // Joins the two design ends.
   dfd_link_if  link_b ();             // Second device end, host side by hand.

   always #10 i_ref_clk = ~i_ref_clk;

   dfd_dev_end dfd_dev_end_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(link_a.device),
      .i_cfg_wr(cfg_wr), .i_dma_global_enable(en), .i_dma_mode_select(mode),
      .i_dma_direction_select(dir), .i_stop_len(stop_len), .i_input_fifo_lower_limit(ll),
      .i_output_fifo_upper_limit(ul), .i_in_fifo_load(in_load), .i_out_fifo_load(out_load),
      .o_wr_valid(wr_valid), .o_wr_data(wr_data), .i_wr_ready(wr_ready), .i_rd_data(rd_head),
      .o_rd_pop(rd_pop), .o_busy(busy));
   dfd_dev_end dfd_dev_end_b_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(link_b.device),
      .i_cfg_wr(cfg_wr), .i_dma_global_enable(en), .i_dma_mode_select(mode),
      .i_dma_direction_select(dir), .i_stop_len(stop_len), .i_input_fifo_lower_limit(ll),
      .i_output_fifo_upper_limit(ul), .i_in_fifo_load(in_load), .i_out_fifo_load(out_load),
      .o_wr_valid(), .o_wr_data(), .i_wr_ready(1'h1), .i_rd_data(rd_head),
      .o_rd_pop(), .o_busy());
   dfd_host_end dfd_host_end_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(link_a.host),
      .i_host_channel_enable(h_en), .i_host_channel_pause(1'h0), .i_demand(h_dmd),
      .i_write_dir(h_wr), .i_block_len(8'h03), .i_tx_data(tx_word), .i_tx_valid(1'h1),
      .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_stop_err(stop_err));
   dfd_link_sva dfd_link_sva_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
      .dma_request_out(link_a.dma_request_out), .host_dma_stop_out(link_a.host_dma_stop_out),
      .dma_acknowledge_in_n(link_a.dma_acknowledge_in_n),
      .host_chip_select_n(link_a.host_chip_select_n), .host_wr_data(link_a.host_wr_data));

   // Compares one value and reports a mismatch at once.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask

   task wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   // Waits for the request level; a hang counts as a mismatch.
   task automatic wait_req(input logic lvl);
      int k;
      for (k = 0; k < 3000 && link_a.dma_request_out !== lvl; k++) tick(1);
      if (k == 3000) begin
         mismatches++;
         wrap_up();
      end
   endtask

   // One settings load; all fields go in together, as the device takes them.
   task cfg(input logic e, m, d, input logic [4:0] s, input logic [6:0] l, u);
      tick(1);
      {en, mode, dir, stop_len, ll, ul} = {e, m, d, s, l, u};
      cfg_wr = 1'h1;
      tick(1);
      cfg_wr = 1'h0;
   endtask

   // Stimulus side of both FIFOs advances on the falling edge.
   always @(negedge i_ref_clk) begin
      tx_word <= tx_word + {31'h0, tx_ready};
      rd_head <= rd_head + {31'h0, rd_pop};
   end

   // Edge counters and word checks; a lost or doubled word breaks the sequence.
   always @(posedge i_ref_clk) begin
      ack_q <= link_a.dma_acknowledge_in_n;
      req_q <= link_a.dma_request_out;
      if (ack_q === 1'h1 && link_a.dma_acknowledge_in_n === 1'h0) ack_falls++;
      if (req_q === 1'h1 && link_a.dma_request_out === 1'h0) req_falls++;
      if (wr_valid === 1'h1 && wr_ready === 1'h1) begin
         chk(wr_data, exp_w);
         exp_w = exp_w + 32'h1;
         wcount++;
      end
      if (rx_valid === 1'h1) begin
         chk(rx_data, exp_r);
         exp_r = exp_r + 32'h1;
         rcount++;
      end
   end

   // Demand write with a stalled sink first, then one full fill cycle.
   task t_write;
      wr_ready = 1'h0;
      cfg(1'h1, 1'h1, 1'h1, 5'h07, 7'h3F, 7'h01);
      {h_dmd, h_wr, h_en} = 3'h7;
      wcount = 0;
      tick(80);
      chk(32'(wcount), 32'h0);
      chk(32'(link_a.dma_request_out), 32'h0);
      wr_ready = 1'h1;
      wait_req(1'h1);
      wait_req(1'h0);
      tick(2);
      chk(32'(wcount), 32'h40);
      h_en = 1'h0;
      tick(20);
      cfg(1'h0, 1'h1, 1'h1, 5'h07, 7'h3F, 7'h01);
      tick(40);
   endtask

   // Demand read: start threshold at its boundary, then count the words.
   task t_read;
      out_load = 7'h02;
      cfg(1'h1, 1'h1, 1'h0, 5'h07, 7'h3F, 7'h03);
      {h_dmd, h_wr, h_en} = 3'h5;
      rcount = 0;
      tick(40);
      chk(32'(link_a.dma_request_out), 32'h0);
      out_load = 7'h03;
      wait_req(1'h1);
      wait_req(1'h0);
      tick(1);
      chk(32'(rcount), 32'h3);
      h_en = 1'h0;
      tick(20);
      cfg(1'h0, 1'h1, 1'h0, 5'h07, 7'h3F, 7'h03);
      tick(40);
   endtask

   // Edge mode: foreign acknowledge ignored, own one drops, toggles per word.
   task automatic t_edge;
      int k;
      {h_dmd, h_wr} = 2'h1;
      cfg(1'h1, 1'h0, 1'h1, 5'h07, 7'h3F, 7'h01);
      wait_req(1'h1);
      link_b.dma_acknowledge_in_n = 1'h0;
      tick(4);
      link_b.dma_acknowledge_in_n = 1'h1;
      tick(8);
      chk(32'(link_b.dma_request_out), 32'h1);
      {link_b.dma_acknowledge_in_n, link_b.host_chip_select_n} = 2'h0;
      for (k = 0; k < 6 && link_b.dma_request_out === 1'h1; k++) tick(1);
      chk(32'(k < 6), 32'h1);
      {link_b.dma_acknowledge_in_n, link_b.host_chip_select_n} = 2'h3;
      {ack_falls, req_falls} = {32'h0, 32'h0};
      {h_dmd, h_wr, h_en} = 3'h3;
      for (k = 0; k < 400 && ack_falls < 6; k++) tick(1);
      if (k == 400) begin
         mismatches++;
         wrap_up();
      end
      tick(6);
      chk(32'(req_falls), 32'h6);
      h_en = 1'h0;
      tick(20);
      cfg(1'h0, 1'h0, 1'h1, 5'h07, 7'h3F, 7'h01);
      tick(40);
   endtask

   // Request outlives the host, then disable fires a stop of the set length.
   task automatic t_stop;
      int w = 0, e = 0;
      cfg(1'h1, 1'h1, 1'h1, 5'h03, 7'h3F, 7'h01);
      wait_req(1'h1);
      tick(60);
      chk(32'(link_a.dma_request_out), 32'h1);
      chk(32'(busy), 32'h1);
      cfg(1'h0, 1'h1, 1'h1, 5'h03, 7'h3F, 7'h01);
      repeat (12) begin
         w += int'(link_a.host_dma_stop_out === 1'h1);
         e += int'(stop_err === 1'h1);
         tick(1);
      end
      chk(32'(w), 32'h3);
      chk(32'(e != 0), 32'h1);
      chk(32'(link_a.dma_request_out), 32'h0);
   endtask

   // Main sequence: reset for 16 cycles, then each scenario in turn.
   initial begin
      {link_b.dma_acknowledge_in_n, link_b.host_chip_select_n} = 2'h3;
      link_b.host_wr_data = 32'h0;
      tick(16);
      i_srst = 1'h0;
      tick(2);
      chk(32'(link_a.dma_request_out), 32'h0);
      t_write();
      t_read();
      t_edge();
      t_stop();
      wrap_up();
   end
endmodule
